/* fsh_regs.svh */
`ifndef FSH_REGS_SVH
`define FSH_REGS_SVH
// clock rate and counter widths
`define FSH_CLK_MHZ        125
`define FSH_TMR_W          17
`define FSH_CNT_W          10
`define FSH_ACC_W          24
// program timing, microseconds
`define FSH_WEN_SET_US     1
`define FSH_PSETUP_SET_US  50
`define FSH_P_SHORT_US     30
`define FSH_P_LONG_US      200
`define FSH_P_SHORT_CNT    6
`define FSH_P_CLR_US       5
`define FSH_PSETUP_CLR_US  5
`define FSH_PVFY_SET_US    4
`define FSH_DUMMY_US       2
`define FSH_PVFY_CLR_US    2
`define FSH_WEN_CLR_US     100
`define FSH_PROG_MAX       1000
`define FSH_PROG_UNIT      64
// erase timing
`define FSH_ESETUP_SET_US  100
`define FSH_E_MIN_MS       10
`define FSH_E_MAX_MS       100
`define FSH_US_PER_MS      1000
`define FSH_E_CLR_US       10
`define FSH_ESETUP_CLR_US  10
`define FSH_EVFY_SET_US    20
`define FSH_EVFY_CLR_US    4
`define FSH_ERASE_MAX      120
`endif

/* fsh_pkg.sv */
package fsh_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SETUP_ON,
    ST_PULSE_ON,
    ST_PULSE_OFF,
    ST_SETUP_OFF,
    ST_VFY_ON,
    ST_DUMMY,
    ST_READ,
    ST_VFY_OFF,
    ST_DECIDE,
    ST_FINISH
  } fsh_state_t;
endpackage

/* fsh_us_tick.sv */
`timescale 1ns/10ps
`default_nettype none
// one-cycle pulse every DIV clocks; clear restarts the phase so a wait is never short
module fsh_us_tick #(
  parameter int DIV = 125
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  input  wire logic clear_in,
  output logic      tick_out
);
  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] div_q;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_q <= '0;
    end else if (clear_in || div_q == LAST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + W'(1);
    end
  end

  assign tick_out = (div_q == LAST) && !clear_in;
endmodule
`default_nettype wire

/* fsh_wait_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module fsh_wait_timer #(
  parameter int W = 17
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] len_in,
  input  wire logic         tick_in,
  output logic              done_out
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
    end else if (load_in) begin
      cnt_q <= len_in;
    end else if (tick_in && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign done_out = (cnt_q == '0);
endmodule
`default_nettype wire

/* fsh_flash_seq.sv */
// Operation
// - wait 2 us after program verify clear
// - wait 100 us after write enable clear
// - cap program pulses at 1000
// - program pulse 30 us, then 200 us
// - wait 1 us after write enable set
// - wait 100 us after erase setup set
// - erase pulse between 10 and 100 ms
// - wait 10 us after erase pulse clear
// - wait 10 us after erase setup clear
// - wait 20 us before erase dummy write
// - wait 2 us after dummy write
// - wait 4 us after erase verify clear
// - cap erase pulses at 120
// - wait 5 us after pulse, setup clear
// - wait 4 us after program verify set
`include "fsh_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module fsh_flash_seq
  import fsh_pkg::*;
#(
  parameter int CYC_PER_US     = `FSH_CLK_MHZ,
  parameter int PSETUP_SET_US  = `FSH_PSETUP_SET_US,
  parameter int ESETUP_SET_US  = `FSH_ESETUP_SET_US,
  parameter int WEN_CLR_US     = `FSH_WEN_CLR_US,
  parameter int ERASE_PULSE_US = `FSH_E_MIN_MS * `FSH_US_PER_MS,
  parameter int PROG_MAX_CNT   = `FSH_PROG_MAX,
  parameter int ERASE_MAX_CNT  = `FSH_ERASE_MAX
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  prog_start_in,
  input  wire logic                  erase_start_in,
  input  wire logic                  verify_ok_in,
  output logic                       busy_out,
  output logic                       done_out,
  output logic                       fail_out,
  output logic [`FSH_CNT_W-1:0]      pulse_count_out,
  output logic [`FSH_ACC_W-1:0]      pulse_time_us_out,
  output logic                       write_enable_bit_out,
  output logic                       program_setup_bit_out,
  output logic                       program_pulse_bit_out,
  output logic                       program_verify_bit_out,
  output logic                       erase_setup_bit_out,
  output logic                       erase_pulse_bit_out,
  output logic                       erase_verify_bit_out,
  output logic                       dummy_wr_out,
  output logic                       verify_rd_out
);
  localparam int TW = `FSH_TMR_W;
  localparam int CW = `FSH_CNT_W;
  localparam int AW = `FSH_ACC_W;

  function automatic int clamp_us(input int v, input int lo, input int hi);
    clamp_us = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // pulse n (1-based) is short for the first few tries, long afterwards
  function automatic logic [TW-1:0] prog_width(input logic [CW-1:0] n);
    prog_width = (n <= CW'(`FSH_P_SHORT_CNT)) ? TW'(`FSH_P_SHORT_US) : TW'(`FSH_P_LONG_US);
  endfunction

  function automatic logic [TW-1:0] pick(input logic erase, input int e_us, input int p_us);
    pick = erase ? TW'(e_us) : TW'(p_us);
  endfunction

  // an out-of-range pulse setting is pulled into the legal window, never trusted
  localparam int E_WIDTH_US = clamp_us(ERASE_PULSE_US, `FSH_E_MIN_MS * `FSH_US_PER_MS,
                                       `FSH_E_MAX_MS * `FSH_US_PER_MS);
  localparam logic [CW-1:0] PROG_CAP  = CW'(PROG_MAX_CNT);
  localparam logic [CW-1:0] ERASE_CAP = CW'(ERASE_MAX_CNT);

  fsh_state_t      state_q;
  fsh_state_t      state_d;
  logic            erase_q;
  logic            wen_q;
  logic            wen_d;
  logic            setup_q;
  logic            setup_d;
  logic            pulse_q;
  logic            pulse_d;
  logic            vfy_q;
  logic            vfy_d;
  logic            dummy_q;
  logic            dummy_d;
  logic            rd_q;
  logic            rd_d;
  logic            ok_q;
  logic            done_q;
  logic            fail_q;
  logic [CW-1:0]   cnt_q;
  logic [AW-1:0]   acc_q;
  logic            tmr_ld;
  logic [TW-1:0]   tmr_us;
  logic            tmr_done;
  logic            tick;
  logic            start;
  logic            at_cap;

  fsh_us_tick #(
    .DIV (CYC_PER_US)
  ) u_tick (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .clear_in   (tmr_ld),
    .tick_out   (tick)
  );

  // each wait is whole microseconds of whole ticks, restarted on load
  fsh_wait_timer #(
    .W (TW)
  ) u_timer (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .load_in    (tmr_ld),
    .len_in     (tmr_us),
    .tick_in    (tick),
    .done_out   (tmr_done)
  );

  assign start  = (state_q == ST_IDLE) && (prog_start_in || erase_start_in);
  assign at_cap = erase_q ? (cnt_q >= ERASE_CAP) : (cnt_q >= PROG_CAP);

  always_comb begin
    state_d = state_q;
    tmr_ld  = 1'b0;
    tmr_us  = '0;
    wen_d   = wen_q;
    setup_d = setup_q;
    pulse_d = pulse_q;
    vfy_d   = vfy_q;
    dummy_d = 1'b0;
    rd_d    = 1'b0;
    if (tmr_done) begin
      case (state_q)
        ST_IDLE: begin
          if (prog_start_in || erase_start_in) begin
            wen_d   = 1'b1;
            tmr_ld  = 1'b1;
            tmr_us  = TW'(`FSH_WEN_SET_US);
            state_d = ST_SETUP_ON;
          end
        end
        ST_SETUP_ON: begin
          setup_d = 1'b1;
          tmr_ld  = 1'b1;
          tmr_us  = pick(erase_q, ESETUP_SET_US, PSETUP_SET_US);
          state_d = ST_PULSE_ON;
        end
        ST_PULSE_ON: begin
          pulse_d = 1'b1;
          tmr_ld  = 1'b1;
          tmr_us  = erase_q ? TW'(E_WIDTH_US) : prog_width(cnt_q + CW'(1));
          state_d = ST_PULSE_OFF;
        end
        ST_PULSE_OFF: begin
          pulse_d = 1'b0;
          tmr_ld  = 1'b1;
          tmr_us  = pick(erase_q, `FSH_E_CLR_US, `FSH_P_CLR_US);
          state_d = ST_SETUP_OFF;
        end
        ST_SETUP_OFF: begin
          setup_d = 1'b0;
          tmr_ld  = 1'b1;
          tmr_us  = pick(erase_q, `FSH_ESETUP_CLR_US, `FSH_PSETUP_CLR_US);
          state_d = ST_VFY_ON;
        end
        ST_VFY_ON: begin
          vfy_d   = 1'b1;
          tmr_ld  = 1'b1;
          tmr_us  = pick(erase_q, `FSH_EVFY_SET_US, `FSH_PVFY_SET_US);
          state_d = ST_DUMMY;
        end
        ST_DUMMY: begin
          dummy_d = 1'b1;
          tmr_ld  = 1'b1;
          tmr_us  = TW'(`FSH_DUMMY_US);
          state_d = ST_READ;
        end
        ST_READ: begin
          rd_d    = 1'b1;
          state_d = ST_VFY_OFF;
        end
        ST_VFY_OFF: begin
          vfy_d   = 1'b0;
          tmr_ld  = 1'b1;
          tmr_us  = pick(erase_q, `FSH_EVFY_CLR_US, `FSH_PVFY_CLR_US);
          state_d = ST_DECIDE;
        end
        ST_DECIDE: begin
          if (ok_q || at_cap) begin
            wen_d   = 1'b0;
            tmr_ld  = 1'b1;
            tmr_us  = TW'(WEN_CLR_US);
            state_d = ST_FINISH;
          end else begin
            state_d = ST_SETUP_ON;
          end
        end
        ST_FINISH: begin
          state_d = ST_IDLE;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      erase_q <= 1'b0;
    end else if (start && tmr_done) begin
      // erase wins if both are asked in one cycle
      erase_q <= erase_start_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wen_q   <= 1'b0;
      setup_q <= 1'b0;
      pulse_q <= 1'b0;
      vfy_q   <= 1'b0;
    end else begin
      wen_q   <= wen_d;
      setup_q <= setup_d;
      pulse_q <= pulse_d;
      vfy_q   <= vfy_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dummy_q <= 1'b0;
      rd_q    <= 1'b0;
    end else begin
      dummy_q <= dummy_d;
      rd_q    <= rd_d;
    end
  end

  // compare result is taken while the read strobe is up
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ok_q <= 1'b0;
    end else if (start) begin
      ok_q <= 1'b0;
    end else if (rd_q) begin
      ok_q <= verify_ok_in;
    end
  end

  // only pulse-on time is summed; verify phases never add to it
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      acc_q <= '0;
    end else if (start && tmr_done) begin
      cnt_q <= '0;
      acc_q <= '0;
    end else if (state_q == ST_PULSE_ON && tmr_done) begin
      cnt_q <= cnt_q + CW'(1);
      acc_q <= acc_q + AW'(tmr_us);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      done_q <= (state_q == ST_FINISH) && tmr_done;
      if (start && tmr_done) begin
        fail_q <= 1'b0;
      end else if (state_q == ST_DECIDE && tmr_done && !ok_q && at_cap) begin
        fail_q <= 1'b1;
      end
    end
  end

  assign busy_out               = (state_q != ST_IDLE);
  assign done_out               = done_q;
  assign fail_out               = fail_q;
  assign pulse_count_out        = cnt_q;
  assign pulse_time_us_out      = acc_q;
  assign write_enable_bit_out   = wen_q;
  assign program_setup_bit_out  = setup_q && !erase_q;
  assign program_pulse_bit_out  = pulse_q && !erase_q;
  assign program_verify_bit_out = vfy_q && !erase_q;
  assign erase_setup_bit_out    = setup_q && erase_q;
  assign erase_pulse_bit_out    = pulse_q && erase_q;
  assign erase_verify_bit_out   = vfy_q && erase_q;
  assign dummy_wr_out           = dummy_q;
  assign verify_rd_out          = rd_q;

  // cycles since the last change on the pins toward the flash
  localparam int C = CYC_PER_US;
  logic [31:0] gap_q;
  logic        chg;
  logic        pv_clr_q;
  assign chg = (wen_d != wen_q) || (setup_d != setup_q) || (pulse_d != pulse_q)
               || (vfy_d != vfy_q) || dummy_d || rd_d;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gap_q    <= 32'h0;
      pv_clr_q <= 1'b0;
    end else if (chg) begin
      gap_q    <= 32'h1;
      pv_clr_q <= vfy_q && !vfy_d && !erase_q;
    end else if (gap_q != 32'hffffffff) begin
      gap_q <= gap_q + 32'h1;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  // next pin change after a program verify clear, measured at that change
  sequence pv_dropped_s;
    chg && pv_clr_q;
  endsequence
  pv_clr_wait_a: assert property (pv_dropped_s |->
    gap_q >= 32'(`FSH_PVFY_CLR_US * C))
    else $error("program verify clear wait too short");
  // gap_q restarts on the change itself, so edge checks look one cycle back
  wen_clr_wait_a: assert property ($rose(done_out) |->
    $past(gap_q) >= 32'(WEN_CLR_US * C))
    else $error("write enable clear wait too short");
  prog_cap_a: assert property ($rose(program_pulse_bit_out) |-> cnt_q <= PROG_CAP)
    else $error("program pulse count above cap");
  prog_width_a: assert property ($fell(program_pulse_bit_out) |->
    $past(gap_q) >= ((cnt_q <= CW'(6)) ?
    32'(`FSH_P_SHORT_US * C) : 32'(`FSH_P_LONG_US * C)))
    else $error("program pulse width wrong");
  wen_set_wait_a: assert property ($rose(erase_setup_bit_out) |->
    $past(gap_q) >= 32'(C))
    else $error("erase setup set too early");
  esetup_wait_a: assert property ($rose(erase_pulse_bit_out) |->
    $past(gap_q) >= 32'(ESETUP_SET_US * C))
    else $error("erase pulse set too early");
  erase_width_a: assert property ($fell(erase_pulse_bit_out) |->
    $past(gap_q) >= 32'(`FSH_E_MIN_MS * `FSH_US_PER_MS * C) &&
    $past(gap_q) <= 32'(`FSH_E_MAX_MS * `FSH_US_PER_MS * C))
    else $error("erase pulse width out of range");
  epulse_clr_a: assert property ($fell(erase_setup_bit_out) |->
    $past(gap_q) >= 32'(`FSH_E_CLR_US * C))
    else $error("erase setup cleared too early");
  esetup_clr_a: assert property ($rose(erase_verify_bit_out) |->
    $past(gap_q) >= 32'(`FSH_ESETUP_CLR_US * C))
    else $error("erase verify set too early");
  edummy_wait_a: assert property ($rose(dummy_wr_out) && erase_verify_bit_out |->
    $past(gap_q) >= 32'(`FSH_EVFY_SET_US * C))
    else $error("erase dummy write too early");
  read_wait_a: assert property ($rose(verify_rd_out) |->
    $past(gap_q) >= 32'(`FSH_DUMMY_US * C))
    else $error("verify read too early after dummy write");
  erase_cap_a: assert property ($rose(erase_pulse_bit_out) |-> cnt_q <= ERASE_CAP)
    else $error("erase pulse count above cap");
endmodule
`default_nettype wire

/* fsh_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fsh_flash_model #(
  parameter int C = 2
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       wen_in,
  input  wire logic       p_setup_in,
  input  wire logic       p_pulse_in,
  input  wire logic       p_vfy_in,
  input  wire logic       e_setup_in,
  input  wire logic       e_pulse_in,
  input  wire logic       e_vfy_in,
  input  wire logic       dummy_in,
  input  wire logic       rd_in,
  input  wire logic [9:0] pass_after_in,
  output logic            verify_ok_out,
  output logic [15:0]     err_out
);
  localparam int BIG = 32'h7fffffff;
  int   cyc, n, rd, w, pw, t_w, t_s, t_p, t_pf, t_sf, t_v, t_d, t_vf, t_wf;
  logic er, tog, ow, os, op, ov;
  wire logic stp = p_setup_in | e_setup_in;
  wire logic pls = p_pulse_in | e_pulse_in;
  wire logic vfy = p_vfy_in | e_vfy_in;
  // compare result only valid in the read cycle; toggles otherwise
  assign verify_ok_out = rd_in ? (rd + 1 >= pass_after_in) : tog;

  // gap limits in clock cycles scaled by C
  task lim(input int got, input int lo, input int hi);
    if (got < lo || got > hi) begin
      err_out++;
      $display("[ERR] t=%0t gap %h limit %h", $time, got, lo);
    end
  endtask

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cyc = 0;
      n = 0;
      rd <= 0;
      t_wf = -100000;
      err_out = 16'h0000;
      tog = 1'b0;
      {ow, os, op, ov} = 4'h0;
    end else begin
      cyc++;
      tog = ~tog;
      lim(int'((stp | pls | vfy) & ~wen_in), 0, 0);
      if (wen_in && !ow) begin
        lim(cyc - t_wf, 100 * C, BIG);
        t_w = cyc;
        n = 0;
        rd <= 0;
      end
      if (stp && !os) begin
        er = e_setup_in;
        lim(cyc - (n ? t_vf : t_w), (n ? (er ? 4 : 2) : 1) * C, BIG);
        t_s = cyc;
      end
      if (pls && !op) begin
        lim(cyc - t_s, (er ? 100 : 50) * C, BIG);
        n++;
        lim(n, 1, er ? 120 : 1000);
        t_p = cyc;
      end
      if (!pls && op) begin
        w = cyc - t_p;
        pw = (n <= 6) ? 30 : 200;
        if (er) lim(w, 10000 * C, 100000 * C);
        else lim(w, pw * C, pw * C + 2);
        t_pf = cyc;
      end
      if (!stp && os) begin
        lim(cyc - t_pf, (er ? 10 : 5) * C, BIG);
        t_sf = cyc;
      end
      if (vfy && !ov) begin
        lim(cyc - t_sf, (er ? 10 : 5) * C, BIG);
        t_v = cyc;
      end
      if (dummy_in) begin
        lim(cyc - t_v, (er ? 20 : 4) * C, BIG);
        t_d = cyc;
      end
      if (rd_in) begin
        lim(cyc - t_d, 2 * C, BIG);
        rd <= rd + 1;
      end
      if (!vfy && ov) t_vf = cyc;
      if (!wen_in && ow) begin
        lim(cyc - t_vf, (er ? 4 : 2) * C, BIG);
        t_wf = cyc;
      end
      {ow, os, op, ov} = {wen_in, stp, pls, vfy};
    end
  end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        ref_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        prog_start_in = 1'b0;
  logic        erase_start_in = 1'b0;
  logic        verify_ok_in;
  logic        busy_out, done_out, fail_out, dummy_wr_out, verify_rd_out;
  logic        wen, program_setup_bit, ppl, pvf, erase_setup_bit, epl, evf, sawp, sawe;
  logic [9:0]  pulse_count_out;
  logic [23:0] pulse_time_us_out;
  logic [9:0]  pass_after = 10'h001;
  logic [15:0] model_err;
  int          n_errors = 0;
  int          comparisons = 0;

  always #4 ref_clk_in = ~ref_clk_in;

  fsh_flash_seq #(.CYC_PER_US(2), .PROG_MAX_CNT(8), .ERASE_MAX_CNT(2)) DUT (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .prog_start_in(prog_start_in),
    .erase_start_in(erase_start_in), .verify_ok_in(verify_ok_in), .busy_out(busy_out),
    .done_out(done_out), .fail_out(fail_out), .pulse_count_out(pulse_count_out),
    .pulse_time_us_out(pulse_time_us_out), .write_enable_bit_out(wen),
    .program_setup_bit_out(program_setup_bit), .program_pulse_bit_out(ppl), .program_verify_bit_out(pvf),
    .erase_setup_bit_out(erase_setup_bit), .erase_pulse_bit_out(epl), .erase_verify_bit_out(evf),
    .dummy_wr_out(dummy_wr_out), .verify_rd_out(verify_rd_out));

  fsh_flash_model #(.C(2)) MDL (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .wen_in(wen), .p_setup_in(program_setup_bit),
    .p_pulse_in(ppl), .p_vfy_in(pvf), .e_setup_in(erase_setup_bit), .e_pulse_in(epl), .e_vfy_in(evf),
    .dummy_in(dummy_wr_out), .rd_in(verify_rd_out), .pass_after_in(pass_after),
    .verify_ok_out(verify_ok_in), .err_out(model_err));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task results;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one sequence; poke raises the other start mid-run, which must be ignored
  task op(input logic p, input logic e, input logic [9:0] pa, input logic poke);
    int k;
    int wf;
    logic pw;
    pass_after = pa;
    sawp = 1'b0;
    sawe = 1'b0;
    pw = 1'b0;
    wf = 0;
    @(negedge ref_clk_in);
    prog_start_in = p;
    erase_start_in = e;
    @(negedge ref_clk_in);
    prog_start_in = 1'b0;
    erase_start_in = 1'b0;
    chk(busy_out, 1);
    for (k = 0; k < 60000 && done_out !== 1'b1; k++) begin
      @(negedge ref_clk_in);
      if (poke) {prog_start_in, erase_start_in} = (k == 10) ? {e, p} : 2'b00;
      sawp = sawp | ppl;
      sawe = sawe | epl;
      if (pw && !wen) wf = k;
      pw = wen;
    end
    chk(done_out, 1);
    chk(busy_out, 0);
    chk(k - wf >= 200, 1);
  endtask

  task t_reset;
    chk({busy_out, done_out, fail_out, wen, program_setup_bit, ppl, pvf, erase_setup_bit, epl, evf, dummy_wr_out,
         verify_rd_out, pulse_count_out}, 0);
    chk(pulse_time_us_out, 0);
  endtask

  task t_prog_cap;
    op(1'b1, 1'b0, 10'h3ff, 1'b1);
    chk(pulse_count_out, 8);
    chk(pulse_time_us_out, 6 * 30 + 2 * 200);
    chk(fail_out, 1);
    chk(sawe, 0);
  endtask

  task t_prog_first;
    op(1'b1, 1'b0, 10'h001, 1'b0);
    chk(pulse_count_out, 1);
    chk(pulse_time_us_out, 30);
    chk(fail_out, 0);
  endtask

  task t_prog_seventh;
    op(1'b1, 1'b0, 10'h007, 1'b0);
    chk(pulse_count_out, 7);
    chk(pulse_time_us_out, 6 * 30 + 200);
    chk(fail_out, 0);
  endtask

  task t_erase_cap;
    op(1'b0, 1'b1, 10'h3ff, 1'b1);
    chk(pulse_count_out, 2);
    chk(pulse_time_us_out, 2 * 10000);
    chk(fail_out, 1);
    chk(sawp, 0);
  endtask

  task t_both;
    op(1'b1, 1'b1, 10'h001, 1'b0);
    chk({sawe, sawp}, 2'b10);
    chk(pulse_time_us_out, 10000);
    chk(fail_out, 0);
  endtask

  initial begin
    // about 66k cycles expected; stop at 87.5k
    #700000;
    n_errors++;
    results;
  end

  initial begin
    repeat (2) @(negedge ref_clk_in);
    t_reset;
    rst_b_in = 1'b1;
    @(negedge ref_clk_in);
    t_reset;
    t_prog_cap;
    t_prog_first;
    t_prog_seventh;
    t_erase_cap;
    t_both;
    chk(model_err, 0);
    results;
  end
endmodule
`default_nettype wire
